// file: shared/wkc_defines.svh
/*
  Register map, field positions, reset values and timing counts of
  the wake-up flag, reset entry and NMI entry controller.
  Assumes it is included by its bare name after the package.
*/
`ifndef WKC_DEFINES_SVH
`define WKC_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte addresses (one aligned word each)
// ----------------------------------------------------------------
`define WKC_ADDR_FLAGS 8'h00
`define WKC_ADDR_EDGE1 8'h04
`define WKC_ADDR_EDGE2 8'h08
`define WKC_ADDR_PMODE 8'h0C
`define WKC_ADDR_ENAB1 8'h10
`define WKC_ADDR_NFLAG 8'h14
`define WKC_ADDR_STAT 8'h18
`define WKC_ADDR_MASK 8'h1C

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define WKC_WAKE_N 6
`define WKC_NUM_N 4
`define WKC_FLAG_RSVD 2'h3
`define WKC_NMI_EG_BIT 7
`define WKC_WAKE_EN_BIT 5
`define WKC_STAT_WAKE 0
`define WKC_STAT_NUM 1
`define WKC_STAT_NMI 2
`define WKC_STAT_N 3

// ----------------------------------------------------------------
// Reset values and vector locations
// ----------------------------------------------------------------
`define WKC_ZERO6 6'h00
`define WKC_ZERO4 4'h0
`define WKC_ZERO8 8'h00
`define WKC_ZERO3 3'h0
`define WKC_VEC_HI 16'h0000
`define WKC_VEC_LO 16'h0001

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WKC_CLK_NS 5
`define WKC_RST_MIN_CYC 10

`endif

// file: shared/wkc_pkg.sv
/*
  Types shared by the controller, the far-side model and the bench.
  Assumes nothing of its surroundings.
*/
package wkc_pkg;

  // ----------------------------------------------------------------
  // Request source towards the CPU core
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    WKC_SRC_NMI,
    WKC_SRC_NUM0,
    WKC_SRC_NUM1,
    WKC_SRC_NUM2,
    WKC_SRC_NUM3,
    WKC_SRC_WAKE
  } wkc_src_type;

  // Request bundle: valid plus the chosen source
  typedef struct packed {
    logic valid;
    wkc_src_type source;
  } wkc_cpu_req_type;

  // Reset exception sequence
  typedef enum logic [2:0] {
    WKC_ST_MASK,
    WKC_ST_FETCH_HI,
    WKC_ST_FETCH_LO,
    WKC_ST_LOAD,
    WKC_ST_RUN
  } wkc_state_type;

endpackage

// file: tb/tb_top.sv
/*
  Self-checking bench of the wake-up flag, reset and NMI controller.
  Assumes the far-side model and a 200 MHz clock.
*/
`include "wkc_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] VHI = 8'h5A; // Arbitrary vector bytes
  localparam logic [7:0] VLO = 8'hC3;
  logic ref_clk, reset_n, clk_en, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable, num_pins;
  logic nmi_pin, cpu_i_bit, cpu_ack, cpu_halt, ccr_i_set, pc_load;
  logic vec_rd_req, vec_rd_ack, irq, slow, nmi_seen, ccr_seen;
  logic [5:0] wake_pins, sel;
  logic [15:0] pc_value, vec_addr;
  logic [7:0] vec_rd_data;
  logic [31:0] seed;
  wkc_pkg::wkc_cpu_req_type cpu_req;
  logic [31:0] rd_q[$], pc_q[$]; // Expected results in order
  int err_count = 0, checks = 0, cyc = 0;
  wkc_top wkc_top_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .nmi_pin(nmi_pin),
    .numbered_request_pins(num_pins), .wake_pins(wake_pins),
    .cpu_i_bit(cpu_i_bit), .cpu_ack(cpu_ack), .cpu_req(cpu_req),
    .cpu_halt(cpu_halt), .ccr_i_set(ccr_i_set), .pc_load(pc_load),
    .pc_value(pc_value), .vec_rd_req(vec_rd_req), .vec_addr(vec_addr),
    .vec_rd_data(vec_rd_data), .vec_rd_ack(vec_rd_ack), .irq(irq));
  wkc_far_model #(.VEC_HI(VHI), .VEC_LO(VLO)) wkc_far_model_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .slow(slow),
    .vec_rd_req(vec_rd_req), .vec_addr(vec_addr),
    .vec_rd_data(vec_rd_data), .vec_rd_ack(vec_rd_ack),
    .cpu_req(cpu_req), .cpu_ack(cpu_ack));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic cmp(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One bus access; waits for waitrequest low, bounded by the timeout
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [7:0] d, input logic [7:0] e);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    if (!wr) rd_q.push_back({24'h0, e});
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic pin_set(input logic [6:0] v);
    @(posedge ref_clk);
    {nmi_pin, wake_pins} <= v;
    repeat (6) @(posedge ref_clk);
  endtask
  // Reset pulse, then the vector fetch must end in a program start
  task automatic do_reset(input logic s, input int n);
    slow <= s;
    ccr_seen = 1'b0;
    reset_n <= 1'b0;
    pc_q.push_back({16'h0, VHI, VLO});
    repeat (n) @(posedge ref_clk);
    reset_n <= 1'b1;
    do @(posedge ref_clk); while (pc_load !== 1'b1);
    cmp("halt_at_load", 1, {31'h0, cpu_halt});
    cmp("mask_first", 1, {31'h0, ccr_seen});
    repeat (2) @(posedge ref_clk);
    cmp("halt_after", 0, {31'h0, cpu_halt});
    cmp("req_after_reset", 0, {31'h0, cpu_req.valid});
    rd(`WKC_ADDR_FLAGS, 8'hC0);
    $display("Test reset done");
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 8'h00);
  endtask
  // ----------------------------------------------------------------
  // Clock, watcher and timeout
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      cmp("readdata", rd_q.pop_front(), avs_readdata);
    if (pc_load === 1'b1)
      cmp("pc_value", pc_q.pop_front(), {16'h0, pc_value});
    if (cpu_req.valid === 1'b1 && cpu_req.source === wkc_pkg::WKC_SRC_NMI)
      nmi_seen <= 1'b1;
    if (reset_n === 1'b1 && ccr_i_set === 1'b1 && vec_rd_req === 1'b0)
      ccr_seen <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {reset_n, avs_read, avs_write, cpu_i_bit, slow} = 5'h00;
    {clk_en, nmi_pin, num_pins, wake_pins} = 12'hFFF;
    {avs_address, avs_writedata, avs_byteenable} = 44'h0000000000F;
    seed = 32'h00000046;
    do_reset(1'b0, 8);
    seed = xs(seed);
    sel = seed[5:0];
    pin_set({1'b1, ~sel});
    wr(`WKC_ADDR_EDGE2, {2'h0, sel});
    wr(`WKC_ADDR_PMODE, 8'h3F);
    wr(`WKC_ADDR_FLAGS, 8'h00);
    rd(`WKC_ADDR_FLAGS, 8'hC0);
    pin_set({1'b1, sel});
    rd(`WKC_ADDR_FLAGS, 8'hFF);
    rd(`WKC_ADDR_FLAGS, 8'hFF);
    wr(`WKC_ADDR_FLAGS, 8'h3E);
    rd(`WKC_ADDR_FLAGS, 8'hFE);
    wr(`WKC_ADDR_FLAGS, 8'h00);
    pin_set({1'b1, ~sel});
    rd(`WKC_ADDR_FLAGS, 8'hC0);
    // Edge lands in the same cycle as the write of zero
    @(posedge ref_clk);
    wake_pins <= sel;
    wr(`WKC_ADDR_FLAGS, 8'h00);
    rd(`WKC_ADDR_FLAGS, 8'hFF);
    $display("Test wake flags done");
    pin_set({1'b1, sel});
    cmp("req_gated", 0, {31'h0, cpu_req.valid});
    wr(`WKC_ADDR_ENAB1, 8'h20);
    @(posedge ref_clk);
    cmp("req_wake", {28'h0, 1'b1, wkc_pkg::WKC_SRC_WAKE},
        {28'h0, cpu_req});
    rd(`WKC_ADDR_FLAGS, 8'hFF);
    wr(`WKC_ADDR_MASK, 8'h05);
    wr(`WKC_ADDR_EDGE1, 8'h80);
    for (int i = 0; i < 2; i++) begin
      cpu_i_bit <= i[0];
      nmi_seen = 1'b0;
      pin_set({1'b0, sel});
      cmp("nmi_fall", 0, {31'h0, nmi_seen});
      pin_set({1'b1, sel});
      cmp("nmi_rise", 1, {31'h0, nmi_seen});
    end
    $display("Test nmi done");
    cmp("irq_set", 1, {31'h0, irq});
    rd(`WKC_ADDR_STAT, 8'h05);
    repeat (2) @(posedge ref_clk);
    cmp("irq_clear", 0, {31'h0, irq});
    wr(`WKC_ADDR_MASK, 8'h00);
    pin_set({1'b1, ~sel});
    pin_set({1'b1, sel});
    cmp("irq_masked", 0, {31'h0, irq});
    rd(`WKC_ADDR_STAT, 8'h01);
    rd(8'h20, 8'h00);
    $display("Test interrupt done");
    do_reset(1'b1, 10);
    rd(`WKC_ADDR_EDGE2, 8'h00);
    give_verdict();
  end
endmodule

// file: tb/wkc_far_model.sv
/*
  Far-side model: program memory holding the reset vector, and a CPU
  core that takes every request it is offered.
  Assumes the controller's vector port and request bundle.
*/
module wkc_far_model #(
  parameter logic [7:0] VEC_HI = 8'h5A,
  parameter logic [7:0] VEC_LO = 8'hC3
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Pace: 1 = memory answers three cycles late
  input wire logic slow,
  // Vector port
  input wire logic vec_rd_req,
  input wire logic [15:0] vec_addr,
  output logic [7:0] vec_rd_data,
  output logic vec_rd_ack,
  // CPU side
  input wire wkc_pkg::wkc_cpu_req_type cpu_req,
  output logic cpu_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] wait_cnt; // Cycles spent before answering
  // ----------------------------------------------------------------
  // Memory: off the ack the data bus flips every cycle, so a stale
  // byte can never pass for a good one
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_cnt <= 2'h0;
      vec_rd_ack <= 1'b0;
      vec_rd_data <= 8'hFF;
    end else begin
      vec_rd_ack <= 1'b0;
      vec_rd_data <= ~vec_rd_data;
      if (vec_rd_req && !vec_rd_ack && wait_cnt == {slow, slow}) begin
        vec_rd_ack <= 1'b1;
        vec_rd_data <= vec_addr[0] ? VEC_LO : VEC_HI;
        wait_cnt <= 2'h0;
      end else if (vec_rd_req && !vec_rd_ack) begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
  // CPU: one-cycle acknowledge of whatever is offered
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_ack <= 1'b0;
    end else begin
      cpu_ack <= cpu_req.valid && !cpu_ack;
    end
  end
endmodule

// file: verilog/wkc_edge_sync.sv
/*
  Two-flop synchroniser with per-bit selectable edge detection.
  Assumes pins may change at any time relative to ref_clk.
*/
module wkc_edge_sync #(
  parameter int N = 1
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Pins and edge choice (1 = rising)
  input wire logic [N-1:0] pin,
  input wire logic [N-1:0] rise_sel,
  // One-cycle edge pulses
  output logic [N-1:0] edge_hit
);

  logic [N-1:0] meta;  // First stage, read only by sync
  logic [N-1:0] sync;  // Second stage
  logic [N-1:0] prev;  // Delayed copy for edge compare

  // ----------------------------------------------------------------
  // Synchroniser and history
  // ----------------------------------------------------------------
  // Pins idle high after reset, so reset to ones avoids a false edge
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= '1;
      sync <= '1;
      prev <= '1;
    end else if (clk_en) begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
    end
  end

  // Edge compare on settled stages only
  always_comb begin
    edge_hit = clk_en ? ((sync & ~prev & rise_sel) |
                         (~sync & prev & ~rise_sel)) : '0;
  end

endmodule

// file: verilog/wkc_top.sv
/*
  Wake-up flag register, numbered request flags, NMI edge detection,
  request priority towards the CPU core, and the reset exception
  sequence that sets the mask bit and loads the reset vector.
  Assumes an Avalon-MM master with waitrequest, a byte-wide vector
  read port to program memory, and a CPU core that acknowledges
  accepted requests for one cycle.
*/
// Chosen here: the Avalon-MM interface to the registers and the address map.
// Summary of operation
// - Wake flag sets on selected edge, pin enabled
// - Wake flag clears only by writing zero
// - Bits 7,6 read one; flags reset zero
// - Low reset halts and initialises everything
// - After release, set CONDITION_CODE_REGISTER mask bit first
// - Fetch vector at 0000-0001 into PC
// - Sources: NMI, four numbered, six wake; only numbered pins 0,1 have a pin-mode bit, so 2,3 never raise a request
// - NMI sensed on selectable pin edge
// - NMI highest priority, ignores mask bit
// - Wake requests share vector, per-pin edges
// - One group enable gates wake requests
`include "wkc_defines.svh"
module wkc_top (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // External interrupt pins
  input wire logic nmi_pin,
  input wire logic [`WKC_NUM_N-1:0] numbered_request_pins,
  input wire logic [`WKC_WAKE_N-1:0] wake_pins,
  // CPU core
  input wire logic cpu_i_bit,
  input wire logic cpu_ack,
  output wkc_pkg::wkc_cpu_req_type cpu_req,
  output logic cpu_halt,
  output logic ccr_i_set,
  output logic pc_load,
  output logic [15:0] pc_value,
  // Vector read port
  output logic vec_rd_req,
  output logic [15:0] vec_addr,
  input wire logic [7:0] vec_rd_data,
  input wire logic vec_rd_ack,
  // Interrupt to system
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [`WKC_WAKE_N-1:0] wakeup_request_flags;  // Wake flags
  logic [`WKC_NUM_N-1:0] num_flags;   // Numbered request flags
  logic [7:0] edge_select_reg_1;      // NMI edge + numbered edges
  logic [`WKC_WAKE_N-1:0] wake_edges; // Per-pin wake edge choice
  logic [`WKC_WAKE_N-1:0] wake_pmode; // Pin used as interrupt input
  logic [`WKC_NUM_N-1:0] num_pmode;   // Same for numbered pins
  logic [7:0] interrupt_enable_reg_1; // Group and numbered enables
  logic [`WKC_STAT_N-1:0] ev_status;  // Sticky event status
  logic [`WKC_STAT_N-1:0] ev_mask;    // Event mask
  logic nmi_pend;                     // NMI waiting for acceptance
  logic bus_ack;                      // Second cycle of an access
  logic bus_req;                      // Any access present
  logic wr_go;                        // Write takes effect
  logic rd_go;                        // Read data taken
  logic be0;                          // Low byte lane enabled
  logic [`WKC_WAKE_N-1:0] wake_hit;   // Wake edges seen
  logic [`WKC_NUM_N-1:0] num_hit;     // Numbered edges seen
  logic nmi_hit;                      // NMI edge seen
  logic [7:0] flag_clr;               // Wake flags written zero
  logic [7:0] nflag_clr;              // Numbered flags written zero
  logic [`WKC_WAKE_N-1:0] wake_set;   // Wake flag set terms
  logic [`WKC_NUM_N-1:0] num_set;     // Numbered flag set terms
  logic wake_group;                   // Gated wake request
  logic [`WKC_NUM_N-1:0] num_req;     // Gated numbered requests
  logic nmi_eg;                       // NMI rising when 1
  logic running;                      // Reset sequence done
  logic [7:0] next_rdata;             // Read mux
  wkc_pkg::wkc_state_type state;      // Reset sequence state
  wkc_pkg::wkc_cpu_req_type next_req; // Priority result

  // Write of zero clears; writing one leaves the bit alone
  function automatic logic [7:0] clr_mask(input logic [7:0] wd,
                                           input logic hit);
    clr_mask = hit ? ~wd : `WKC_ZERO8;
  endfunction

  // Register address match, used by every register
  function automatic logic at(input logic [7:0] a);
    at = (avs_address == a);
  endfunction

  // ----------------------------------------------------------------
  // Pin edge detection
  // ----------------------------------------------------------------
  assign nmi_eg = edge_select_reg_1[`WKC_NMI_EG_BIT];

  // Six wake pins, each with its own edge choice
  wkc_edge_sync #(.N(`WKC_WAKE_N)) u_wake (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pin(wake_pins),
    .rise_sel(wake_edges),
    .edge_hit(wake_hit)
  );

  // Four numbered request pins
  wkc_edge_sync #(.N(`WKC_NUM_N)) u_num (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pin(numbered_request_pins),
    .rise_sel(edge_select_reg_1[`WKC_NUM_N-1:0]),
    .edge_hit(num_hit)
  );

  // NMI pin with its own edge choice
  wkc_edge_sync #(.N(1)) u_nmi (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pin(nmi_pin),
    .rise_sel(nmi_eg),
    .edge_hit(nmi_hit)
  );

  // Only pins set up as interrupt inputs raise a flag
  assign wake_set = wake_hit & wake_pmode;
  assign num_set = num_hit & num_pmode;

  // ----------------------------------------------------------------
  // Avalon-MM handshake
  // ----------------------------------------------------------------
  // Fixed two-cycle access: the first cycle prepares read data,
  // the second drops waitrequest. Costs a cycle, keeps timing easy.
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~bus_ack;
  assign wr_go = clk_en & avs_write & bus_ack;
  assign rd_go = clk_en & avs_read & bus_ack;
  assign be0 = avs_byteenable[0];

  // Access phase
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_ack <= 1'b0;
    end else if (clk_en) begin
      bus_ack <= bus_req & ~bus_ack;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = `WKC_ZERO8;
    unique case (1'b1)
      at(`WKC_ADDR_FLAGS): begin
        next_rdata = {`WKC_FLAG_RSVD, wakeup_request_flags};
      end
      at(`WKC_ADDR_EDGE1): next_rdata = edge_select_reg_1;
      at(`WKC_ADDR_EDGE2): next_rdata = {2'h0, wake_edges};
      at(`WKC_ADDR_PMODE): next_rdata = {num_pmode[1:0], wake_pmode};
      at(`WKC_ADDR_ENAB1): next_rdata = interrupt_enable_reg_1;
      at(`WKC_ADDR_NFLAG): next_rdata = {4'h0, num_flags};
      at(`WKC_ADDR_STAT): next_rdata = {5'h00, ev_status};
      at(`WKC_ADDR_MASK): next_rdata = {5'h00, ev_mask};
      default: next_rdata = `WKC_ZERO8;
    endcase
  end

  // Read data captured in the first cycle, stands at the ack edge
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h00000000;
    end else if (clk_en && avs_read && !bus_ack) begin
      avs_readdata <= {24'h000000, next_rdata};
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Software written settings; all zero out of reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      edge_select_reg_1 <= `WKC_ZERO8;
      wake_edges <= `WKC_ZERO6;
      wake_pmode <= `WKC_ZERO6;
      num_pmode <= `WKC_ZERO4;
      interrupt_enable_reg_1 <= `WKC_ZERO8;
      ev_mask <= `WKC_ZERO3;
    end else if (wr_go && be0) begin
      if (at(`WKC_ADDR_EDGE1)) begin
        edge_select_reg_1 <= avs_writedata[7:0];
      end
      if (at(`WKC_ADDR_EDGE2)) begin
        wake_edges <= avs_writedata[`WKC_WAKE_N-1:0];
      end
      if (at(`WKC_ADDR_PMODE)) begin
        wake_pmode <= avs_writedata[`WKC_WAKE_N-1:0];
        num_pmode <= {2'h0, avs_writedata[7:6]};
      end
      if (at(`WKC_ADDR_ENAB1)) begin
        interrupt_enable_reg_1 <= avs_writedata[7:0];
      end
      if (at(`WKC_ADDR_MASK)) begin
        ev_mask <= avs_writedata[`WKC_STAT_N-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Request flags
  // ----------------------------------------------------------------
  // Clear terms; a process so the address decode is seen as well
  always_comb begin
    flag_clr = clr_mask(avs_writedata[7:0],
                        wr_go & be0 & at(`WKC_ADDR_FLAGS));
    nflag_clr = clr_mask(avs_writedata[7:0],
                         wr_go & be0 & at(`WKC_ADDR_NFLAG));
  end

  // Wake flags: set by edge, cleared only by a written zero, and
  // the set term is or-ed last so a colliding edge survives.
  // Reading or CPU acceptance leaves them untouched.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wakeup_request_flags <= `WKC_ZERO6;
    end else if (clk_en) begin
      wakeup_request_flags <= (wakeup_request_flags &
        ~flag_clr[`WKC_WAKE_N-1:0])
        | wake_set;
    end
  end

  // Numbered flags follow the same write-zero discipline
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      num_flags <= `WKC_ZERO4;
    end else if (clk_en) begin
      num_flags <= (num_flags & ~nflag_clr[`WKC_NUM_N-1:0])
        | num_set;
    end
  end

  // NMI stays pending until the core takes it; new edge wins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_pend <= 1'b0;
    end else if (clk_en) begin
      if (nmi_hit) begin
        nmi_pend <= 1'b1;
      end else if (cpu_ack && cpu_req.valid &&
                   cpu_req.source == wkc_pkg::WKC_SRC_NMI) begin
        nmi_pend <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Priority towards the CPU core
  // ----------------------------------------------------------------
  // All six wake flags fold onto one request and one vector
  assign wake_group = (|wakeup_request_flags) &
    interrupt_enable_reg_1[`WKC_WAKE_EN_BIT];
  assign num_req = num_flags &
    interrupt_enable_reg_1[`WKC_NUM_N-1:0];

  // Nothing is offered before the reset sequence completes, since
  // the stack pointer is not yet valid. NMI ignores the mask bit.
  always_comb begin
    next_req.valid = 1'b0;
    next_req.source = wkc_pkg::WKC_SRC_NMI;
    if (!running) begin
      next_req.valid = 1'b0;
    end else if (nmi_pend) begin
      next_req.valid = 1'b1;
    end else if (!cpu_i_bit && num_req[0]) begin
      next_req.valid = 1'b1;
      next_req.source = wkc_pkg::WKC_SRC_NUM0;
    end else if (!cpu_i_bit && num_req[1]) begin
      next_req.valid = 1'b1;
      next_req.source = wkc_pkg::WKC_SRC_NUM1;
    end else if (!cpu_i_bit && num_req[2]) begin
      next_req.valid = 1'b1;
      next_req.source = wkc_pkg::WKC_SRC_NUM2;
    end else if (!cpu_i_bit && num_req[3]) begin
      next_req.valid = 1'b1;
      next_req.source = wkc_pkg::WKC_SRC_NUM3;
    end else if (!cpu_i_bit && wake_group) begin
      next_req.valid = 1'b1;
      next_req.source = wkc_pkg::WKC_SRC_WAKE;
    end
  end
  assign cpu_req = next_req;

  // ----------------------------------------------------------------
  // Reset exception sequence
  // ----------------------------------------------------------------
  // Asynchronous reset halts everything; release starts at the
  // mask step. Holding reset long enough is the board's job.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= wkc_pkg::WKC_ST_MASK;
    end else if (clk_en) begin
      unique case (state)
        wkc_pkg::WKC_ST_MASK: begin
          state <= wkc_pkg::WKC_ST_FETCH_HI;
        end
        wkc_pkg::WKC_ST_FETCH_HI: begin
          if (vec_rd_ack) begin
            state <= wkc_pkg::WKC_ST_FETCH_LO;
          end
        end
        wkc_pkg::WKC_ST_FETCH_LO: begin
          if (vec_rd_ack) begin
            state <= wkc_pkg::WKC_ST_LOAD;
          end
        end
        wkc_pkg::WKC_ST_LOAD: begin
          state <= wkc_pkg::WKC_ST_RUN;
        end
        wkc_pkg::WKC_ST_RUN: begin
          state <= wkc_pkg::WKC_ST_RUN;
        end
      endcase
    end
  end

  // Vector bytes, high byte first, gathered into the PC value
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_value <= `WKC_VEC_HI;
    end else if (clk_en && vec_rd_ack) begin
      if (state == wkc_pkg::WKC_ST_FETCH_HI) begin
        pc_value[15:8] <= vec_rd_data;
      end else if (state == wkc_pkg::WKC_ST_FETCH_LO) begin
        pc_value[7:0] <= vec_rd_data;
      end
    end
  end

  // Vector address register follows the fetch steps
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      vec_addr <= `WKC_VEC_HI;
    end else if (clk_en) begin
      if (state == wkc_pkg::WKC_ST_FETCH_HI && vec_rd_ack) begin
        vec_addr <= `WKC_VEC_LO;
      end else if (state == wkc_pkg::WKC_ST_FETCH_LO && vec_rd_ack) begin
        vec_addr <= `WKC_VEC_HI;
      end
    end
  end

  assign running = (state == wkc_pkg::WKC_ST_RUN);
  assign cpu_halt = ~running;
  assign ccr_i_set = clk_en & (state == wkc_pkg::WKC_ST_MASK);
  assign pc_load = clk_en & (state == wkc_pkg::WKC_ST_LOAD);
  assign vec_rd_req = (state == wkc_pkg::WKC_ST_FETCH_HI) |
                      (state == wkc_pkg::WKC_ST_FETCH_LO);

  // ----------------------------------------------------------------
  // Event status and interrupt output
  // ----------------------------------------------------------------
  // Cleared by a read of the status register; a new event in the
  // same cycle wins over that clear.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ev_status <= `WKC_ZERO3;
    end else if (clk_en) begin
      ev_status <= (ev_status &
        ~{`WKC_STAT_N{rd_go & at(`WKC_ADDR_STAT)}})
        | {nmi_hit, |num_set, |wake_set};
    end
  end

  assign irq = |(ev_status & ev_mask);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  chk_wake_set: assert property (clk_en && wake_set[0] |=>
    wakeup_request_flags[0]) else $error("wake flag 0 not set");
  chk_wake_hold: assert property (
    wakeup_request_flags[1] && !(wr_go && at(`WKC_ADDR_FLAGS))
    |=> wakeup_request_flags[1]) else $error("wake flag 1 lost");
  chk_rsvd_ones: assert property (
    clk_en && avs_read && !bus_ack && at(`WKC_ADDR_FLAGS)
    |=> avs_readdata[7:6] == `WKC_FLAG_RSVD)
    else $error("reserved bits not one");
  chk_halt_state: assert property (
    cpu_halt == (state != wkc_pkg::WKC_ST_RUN) && (cpu_halt ||
    !vec_rd_req)) else $error("halt inconsistent");
  chk_mask_first: assert property (
    $rose(vec_rd_req) |-> $past(state) == wkc_pkg::WKC_ST_MASK)
    else $error("fetch before mask step");
  chk_pc_load: assert property (pc_load |=>
    running ##0 $stable(pc_value)) else $error("pc load order");
  chk_nmi_prio: assert property (
    running && nmi_pend |-> cpu_req.valid &&
    cpu_req.source == wkc_pkg::WKC_SRC_NMI)
    else $error("nmi not first");
  chk_nmi_edge: assert property (nmi_hit |=> nmi_pend)
    else $error("nmi edge dropped");
  chk_group_gate: assert property (
    cpu_req.valid && cpu_req.source == wkc_pkg::WKC_SRC_WAKE |->
    interrupt_enable_reg_1[`WKC_WAKE_EN_BIT])
    else $error("wake not gated");
  chk_set_wins: assert property (
    clk_en && wake_set[2] && wr_go && at(`WKC_ADDR_FLAGS)
    |=> wakeup_request_flags[2]) else $error("clear beat edge");
  chk_wait_len: assert property (bus_req && !bus_ack && clk_en
    |=> !avs_waitrequest) else $error("access too long");

  cov_wake_req: cover property (cpu_req.valid &&
    cpu_req.source == wkc_pkg::WKC_SRC_WAKE);
  cov_nmi_req: cover property (running && nmi_pend);
  cov_boot_done: cover property (pc_load ##1 running);
  cov_irq_out: cover property ($rose(irq));

endmodule
